// File: src/fmc_pkg.sv
// fan monitor configuration: offsets, layouts, reset values, timing counts
// assumes an 8-bit register access port fed by the serial management front end
package fmc_pkg;

  // ************************************************
  // register offsets and reset values
  // ************************************************
  localparam logic [7:0] FMC_OFS_LIMIT = 8'h7a;
  localparam logic [7:0] FMC_OFS_PULSE = 8'h7b;
  localparam logic [7:0] FMC_OFS_CFG5  = 8'h7c;
  localparam logic [7:0] FMC_RST_LIMIT = 8'h00;
  localparam logic [7:0] FMC_RST_PULSE = 8'h55;
  localparam logic [7:0] FMC_RST_CFG5  = 8'h00;
  localparam logic [7:0] FMC_RD_UNMAP  = 8'h00;

  // ************************************************
  // thermal timer figures
  // ************************************************
  localparam int         FMC_TICK_TIME_US = 22760;
  localparam int         FMC_CLK_MHZ      = 200;
  localparam int         FMC_TICK_CYCLES  = FMC_TICK_TIME_US * FMC_CLK_MHZ;
  localparam logic [7:0] FMC_STATUS_TICKS = 8'h02;
  localparam logic [7:0] FMC_TMR_MAX      = 8'hff;

  // ************************************************
  // field layouts
  // ************************************************
  typedef struct packed {
    logic [1:0] fourth_fan_pulse_sel;
    logic [1:0] third_fan_pulse_sel;
    logic [1:0] second_fan_pulse_sel;
    logic [1:0] first_fan_pulse_sel;
  } fmc_pulse_sel_s;

  typedef struct packed {
    logic [3:0] unused;
    logic       aux_pin_polarity;
    logic       aux_pin_direction;
    logic       drive_freq_band;
    logic       twos_compl;
  } fmc_cfg5_s;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } fmc_reg_req_s;

endpackage

// File: src/fmc_regs.sv
// fan monitor configuration registers and thermal assertion timer
// assumes reg_req is on sys_clk; overtemp and aux pin come from pins
`timescale 1ns/10ps

// Notes on behaviour
// (R1) limit is 8 bits, one step per 22.76 ms timer tick
// (R2) timer above limit sets the fourth_fan_pulse_sel or timer status flag; the code sets it only while overtemp_signal_mode is high
// (R3) limit zero sets the flag as soon as overtemp is asserted; the code sets it only while overtemp_signal_mode is high
// (R4) limit register is read/write and resets to zero
// (R5) pulse select holds four 2-bit fan fields, fan 1 lowest
// (R6) field code n selects n plus one tach pulses per measurement
// (R7) pulse select register resets to 0x55
// (R8) config bit 0 set selects twos complement, clear selects offset 64
// (R9) format output follows the bit at once after any change
// (R10) config bit 1 zero high drive frequency, one low
// (R11) aux pin enabled: bit 2 zero input, one output
// (R12) aux pin output: bit 3 zero active low, one active high
// (R13) timer status upper seven bits read zero until the timer reaches 45.52 ms
// (R14) fourth_fan_pulse_sel mask suppresses alert for timer event in thermal mode
// (R15) lock set makes config register ignore writes
// (R16) timer compared with limit on every tick while asserted; the code compares only while overtemp_signal_mode is high
// (R17) upper four config bits ignore writes and read zero
module fmc_regs #(
  parameter int TICK_CYCLES = fmc_pkg::FMC_TICK_CYCLES
) (
  input  wire logic                    sys_clk,
  input  wire logic                    rst_n,
  input  wire fmc_pkg::fmc_reg_req_s   reg_req,
  output logic [7:0]                   reg_rdata,
  input  wire logic                    overtemp_signal_n,
  input  wire logic                    overtemp_signal_mode,
  input  wire logic                    fourth_fan_pulse_sel_mask,
  input  wire logic                    flag_clr,
  input  wire logic                    status_rd,
  input  wire logic                    cfg_lock,
  input  wire logic                    aux_pin_en,
  input  wire logic                    aux_pin_level,
  input  wire logic                    aux_pin_in,
  output logic                         aux_pin_out,
  output logic                         aux_pin_oe_n,
  output logic                         aux_pin_state,
  output logic                         fourth_fan_pulse_sel_or_timer_flag,
  output logic                         alert_output_n,
  output logic [7:0]                   timer_status,
  output logic [7:0]                   assert_limit_value,
  output fmc_pkg::fmc_pulse_sel_s      pulse_sel,
  output fmc_pkg::fmc_cfg5_s           cfg5
);
  import fmc_pkg::*;

  // ************************************************
  // state
  // ************************************************
  logic [31:0]    div;
  logic [7:0]     tmr;
  logic           asrt;
  logic           ot_s1;
  logic           ot_s2;
  logic           ot_prev;
  logic           aux_s1;
  logic           aux_s2;
  logic [31:0]    next_div;
  logic [7:0]     next_tmr;
  logic           next_asrt;
  logic           next_flag;
  logic [7:0]     next_limit;
  fmc_pulse_sel_s next_pulse;
  fmc_cfg5_s      next_cfg5;
  logic [7:0]     next_rdata;
  logic [7:0]     next_status;
  logic           next_alert_n;
  logic           next_aux_out;
  logic           next_aux_oe_n;
  logic           tick;
  logic           asserted;

  assign asserted = ~ot_s2;
  assign tick     = (div == 32'(TICK_CYCLES - 1));

  // ************************************************
  // next values
  // ************************************************
  always_comb begin
    next_limit = assert_limit_value;
    next_pulse = pulse_sel;
    next_cfg5  = cfg5;
    next_rdata = reg_rdata;
    if (reg_req.wr) begin
      unique case (reg_req.addr)
        FMC_OFS_LIMIT: next_limit = reg_req.wdata; // R4 R1
        FMC_OFS_PULSE: next_pulse = fmc_pulse_sel_s'(reg_req.wdata); // R5 R6
        FMC_OFS_CFG5: begin
          if (!cfg_lock) begin // R15
            next_cfg5 = fmc_cfg5_s'({4'h0, reg_req.wdata[3:0]}); // R17 R8 R10 R11 R12
          end
        end
        default: next_limit = assert_limit_value;
      endcase
    end
    if (reg_req.rd) begin
      unique case (reg_req.addr)
        FMC_OFS_LIMIT: next_rdata = assert_limit_value;
        FMC_OFS_PULSE: next_rdata = pulse_sel;
        FMC_OFS_CFG5:  next_rdata = cfg5;
        default:       next_rdata = FMC_RD_UNMAP;
      endcase
    end
    next_div = tick ? 32'h0 : div + 32'h1;
    next_tmr = tmr;
    if (status_rd) begin
      next_tmr = 8'h00;
    end
    if (asserted && tick && tmr != FMC_TMR_MAX) begin
      next_tmr = tmr + 8'h01;
    end
    next_asrt = asrt;
    if (status_rd) begin
      next_asrt = 1'b0;
    end
    if (asserted && !ot_prev) begin
      next_asrt = 1'b1;
    end
    next_flag = fourth_fan_pulse_sel_or_timer_flag;
    if (flag_clr) begin
      next_flag = 1'b0;
    end
    if (overtemp_signal_mode && asserted) begin
      if (assert_limit_value == 8'h00) begin
        next_flag = 1'b1; // R3
      end else if (tick && next_tmr > assert_limit_value) begin
        next_flag = 1'b1; // R16 R2
      end
    end
    next_status   = (next_tmr >= FMC_STATUS_TICKS) ? next_tmr : {7'h00, next_asrt}; // R13
    next_alert_n  = ~(next_flag & overtemp_signal_mode & ~fourth_fan_pulse_sel_mask); // R14
    next_aux_oe_n = ~(aux_pin_en & next_cfg5.aux_pin_direction); // R11
    next_aux_out  = aux_pin_level ? next_cfg5.aux_pin_polarity
                                  : ~next_cfg5.aux_pin_polarity; // R12
  end

  // ************************************************
  // registers
  // ************************************************
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      assert_limit_value <= FMC_RST_LIMIT; // R4
      pulse_sel          <= fmc_pulse_sel_s'(FMC_RST_PULSE); // R7
      cfg5               <= fmc_cfg5_s'(FMC_RST_CFG5); // R17
      reg_rdata          <= 8'h00;
      div                <= 32'h0;
      tmr                <= 8'h00;
      asrt               <= 1'b0;
      fourth_fan_pulse_sel_or_timer_flag <= 1'b0;
      timer_status       <= 8'h00;
      alert_output_n     <= 1'b1;
      aux_pin_out        <= 1'b0;
      aux_pin_oe_n       <= 1'b1;
      aux_pin_state      <= 1'b0;
      ot_s1              <= 1'b1;
      ot_s2              <= 1'b1;
      ot_prev            <= 1'b1;
      aux_s1             <= 1'b0;
      aux_s2             <= 1'b0;
    end else begin
      assert_limit_value <= next_limit;
      pulse_sel          <= next_pulse;
      cfg5               <= next_cfg5; // R9
      reg_rdata          <= next_rdata;
      div                <= next_div;
      tmr                <= next_tmr;
      asrt               <= next_asrt;
      fourth_fan_pulse_sel_or_timer_flag <= next_flag;
      timer_status       <= next_status;
      alert_output_n     <= next_alert_n;
      aux_pin_out        <= next_aux_out;
      aux_pin_oe_n       <= next_aux_oe_n;
      aux_pin_state      <= aux_s2;
      ot_s1              <= overtemp_signal_n;
      ot_s2              <= ot_s1;
      ot_prev            <= ot_s2;
      aux_s1             <= aux_pin_in;
      aux_s2             <= aux_s1;
    end
  end

  // ************************************************
  // assertions
  // ************************************************
  a_zero_limit_flag: assert property (@(posedge sys_clk) disable iff (!rst_n)
    overtemp_signal_mode && asserted && assert_limit_value == 8'h00 |=> fourth_fan_pulse_sel_or_timer_flag) // R3
    else $error("zero limit did not raise flag");
  a_limit_exceed_flag: assert property (@(posedge sys_clk) disable iff (!rst_n)
    overtemp_signal_mode && asserted && tick && tmr != FMC_TMR_MAX
    && (tmr + 8'h01) > assert_limit_value |=> fourth_fan_pulse_sel_or_timer_flag) // R2
    else $error("limit exceeded without flag");
  a_flag_cause: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(fourth_fan_pulse_sel_or_timer_flag) |-> $past(asserted) && $past(overtemp_signal_mode)) // R16
    else $error("flag set without asserted input");
  a_reset_values: assert property (@(posedge sys_clk)
    !rst_n |=> pulse_sel == 8'h55 && assert_limit_value == 8'h00 && cfg5 == 8'h00) // R7
    else $error("wrong reset values");
  a_limit_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
    reg_req.wr && reg_req.addr == FMC_OFS_LIMIT |=> assert_limit_value == $past(reg_req.wdata)) // R4
    else $error("limit write lost");
  a_lock_holds_cfg: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cfg_lock |=> $stable(cfg5)) // R15
    else $error("locked config changed");
  a_unused_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cfg5.unused == 4'h0) // R17
    else $error("unused config bits set");
  a_status_low_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    tmr < FMC_STATUS_TICKS |-> timer_status[7:1] == 7'h00) // R13
    else $error("status upper bits early");
  a_alert_masked: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !alert_output_n |-> fourth_fan_pulse_sel_or_timer_flag && !$past(fourth_fan_pulse_sel_mask)) // R14
    else $error("alert without unmasked flag");
  a_aux_drive_dir: assert property (@(posedge sys_clk) disable iff (!rst_n)
    aux_pin_en && cfg5.aux_pin_direction && !reg_req.wr |=> !aux_pin_oe_n) // R11
    else $error("aux pin not driven");
  a_pulse_readback: assert property (@(posedge sys_clk) disable iff (!rst_n)
    reg_req.rd && reg_req.addr == FMC_OFS_PULSE |=> reg_rdata == $past(pulse_sel)) // R5
    else $error("pulse select readback wrong");

endmodule

// File: sim/fmc_host_model.sv
// host model driving the byte register port of fmc_regs
// assumes sys_clk of the block; requests change on the falling edge
`timescale 1ns/10ps
module fmc_host_model (
  input  wire logic            sys_clk,
  input  wire logic [7:0]      reg_rdata,
  output fmc_pkg::fmc_reg_req_s reg_req
);
  import fmc_pkg::*;
  initial reg_req = '{1'b0, 1'b0, 8'h00, 8'h00};
  // **********************************
  // one request, then idle with bus scrambled
  // **********************************
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(negedge sys_clk);
    reg_req = '{w, ~w, a, d};
    @(negedge sys_clk);
    q = reg_rdata;
    reg_req = '{1'b0, 1'b0, ~a, ~d};
  endtask
endmodule

// File: sim/tb_fmc_regs.sv
// self-checking bench for fmc_regs against an integer register model
// assumes fmc_host_model as register master; short timer tick
`timescale 1ns/10ps
module tb_fmc_regs;
  import fmc_pkg::*;
  localparam int TK = 8;
  logic           sys_clk, rst_n, ot_n, tmode, mask, fclr, srd, lock, aen, alvl, ain;
  logic           aout, aoe_n, ast, flag, alert_n;
  logic [7:0]     rdata, tstat, lim, q, a, d;
  fmc_reg_req_s   req;
  fmc_pulse_sel_s psel;
  fmc_cfg5_s      cfg5;
  int             failures, checks_done, cyc, seed, i, mdiv;
  int             m[int];
  logic [7:0]     ad[4] = '{FMC_OFS_LIMIT, FMC_OFS_PULSE, FMC_OFS_CFG5, 8'h7d};
  fmc_regs #(.TICK_CYCLES(TK)) u_fmc_regs (.sys_clk(sys_clk), .rst_n(rst_n),
    .reg_req(req), .reg_rdata(rdata), .overtemp_signal_n(ot_n), .overtemp_signal_mode(tmode),
    .fourth_fan_pulse_sel_mask(mask), .flag_clr(fclr), .status_rd(srd), .cfg_lock(lock),
    .aux_pin_en(aen), .aux_pin_level(alvl), .aux_pin_in(ain), .aux_pin_out(aout),
    .aux_pin_oe_n(aoe_n), .aux_pin_state(ast), .fourth_fan_pulse_sel_or_timer_flag(flag),
    .alert_output_n(alert_n), .timer_status(tstat), .assert_limit_value(lim),
    .pulse_sel(psel), .cfg5(cfg5));
  fmc_host_model u_fmc_host_model (.sys_clk(sys_clk), .reg_rdata(rdata), .reg_req(req));
  // **********************************
  // clock, timeout, checks
  // **********************************
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    mdiv <= (!rst_n || mdiv == TK - 1) ? 0 : mdiv + 1;
    if (cyc == 3000) begin
      failures++;
      complete_run();
    end
  end
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checks_done++;
    if (s !== e) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic rdc(input logic [7:0] ra);
    u_fmc_host_model.acc(1'b0, ra, 8'h00, q);
    chk(q, m.exists(ra) ? 8'(m[ra]) : FMC_RD_UNMAP);
  endtask
  task automatic wrm(input logic [7:0] wa, input logic [7:0] wd);
    u_fmc_host_model.acc(1'b1, wa, wd, q);
    if (m.exists(wa) && !(wa == FMC_OFS_CFG5 && lock))
      m[wa] = (wa == FMC_OFS_CFG5) ? (wd & 8'h0f) : wd;
  endtask
  // **********************************
  // main sequence
  // **********************************
  initial begin
    {failures, checks_done, cyc, seed} = {32'd0, 32'd0, 32'd0, 32'd99942};
    {rst_n, ot_n, tmode, mask, fclr, srd, lock, aen, alvl, ain} = 10'b0100000000;
    m[FMC_OFS_LIMIT] = 0;
    m[FMC_OFS_PULSE] = 8'h55;
    m[FMC_OFS_CFG5] = 0;
    repeat (5) @(negedge sys_clk);
    rst_n = 1'b1;
    for (i = 0; i < 4; i++) rdc(ad[i]);
    $display("test reset values done");
    for (i = 0; i < 16; i++) begin
      @(negedge sys_clk) lock = 1'($random(seed));
      a = ad[i % 4];
      d = 8'($random(seed));
      wrm(a, d);
      rdc(a);
      chk(psel, 8'(m[FMC_OFS_PULSE]));
      chk(cfg5, 8'(m[FMC_OFS_CFG5]));
      chk(lim, 8'(m[FMC_OFS_LIMIT]));
    end
    $display("test register access done");
    lock = 1'b0;
    for (i = 0; i < 8; i++) begin
      {aen, alvl} = 2'($random(seed));
      ain = i[0];
      d = 8'($random(seed));
      wrm(FMC_OFS_CFG5, d);
      repeat (2) @(negedge sys_clk);
      chk({7'h00, aoe_n}, {7'h00, !(aen && d[2])});
      chk({7'h00, aout}, {7'h00, alvl ? d[3] : ~d[3]});
      chk({7'h00, ast}, {7'h00, ain});
    end
    $display("test aux pin done");
    ot_n = 1'b0;
    wrm(FMC_OFS_LIMIT, 8'h00);
    repeat (4) @(negedge sys_clk);
    chk({7'h00, flag}, 8'h00);
    tmode = 1'b1;
    repeat (2) @(negedge sys_clk);
    chk({7'h00, flag}, 8'h01);
    chk({7'h00, alert_n}, 8'h00);
    mask = 1'b1;
    repeat (2) @(negedge sys_clk);
    chk({7'h00, alert_n}, 8'h01);
    {ot_n, mask} = 2'b10;
    wrm(FMC_OFS_LIMIT, 8'h03);
    {srd, fclr} = 2'b11;
    @(negedge sys_clk) {srd, fclr} = 2'b00;
    chk({7'h00, flag}, 8'h00);
    chk(tstat, 8'h00);
    // align assertion so the first tick lands on the fourth edge
    while (mdiv != 4) @(negedge sys_clk);
    ot_n = 1'b0;
    repeat (11) @(negedge sys_clk);
    chk(tstat, 8'h01);
    repeat (16) @(negedge sys_clk);
    chk({7'h00, flag}, 8'h00);
    @(negedge sys_clk);
    chk({7'h00, flag}, 8'h01);
    chk({7'h00, alert_n}, 8'h00);
    chk(tstat, 8'h04);
    $display("test thermal timer done");
    complete_run();
  end
endmodule
